// *** logic/hsc_pkg.sv ***
package hsc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ    = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0C;
  localparam logic [7:0] OFF_LIMUV0 = 8'h10;
  localparam logic [7:0] OFF_LIMOV0 = 8'h14;
  localparam logic [7:0] OFF_LIMUV1 = 8'h18;
  localparam logic [7:0] OFF_LIMOV1 = 8'h1C;
  localparam logic [7:0] OFF_WARN   = 8'h20;
  // ctrl fields: [1:0] enable_a, [3:2] channel_sw_enable_b
  localparam int CTRL_EN_A_LSB = 0;
  localparam int CTRL_EN_B_LSB = 2;
  // irq fields: [1:0] breaker shutdown, [3:2] power-good lost
  localparam int IRQ_CB_LSB = 0;
  localparam int IRQ_PGL_LSB = 2;
  localparam logic [1:0] EN_A_RESET = 2'h3;
  localparam logic [9:0] UV_RESET = 10'h040;
  localparam logic [9:0] OV_RESET = 10'h3C0;
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int RETRY_MS = 200;
  localparam int RETRY_CYCLES = CLK_HZ / 1000 * RETRY_MS;
  localparam int INIT_CYCLES = 16;
  typedef enum {HSC_INIT, HSC_RUN} hsc_phase_e;
  typedef struct packed {
    logic group_both;
    logic shutdown_on_fault;
    logic good_active_high;
    logic autoretry;
  } hsc_straps_s;
  typedef struct packed {
    logic [9:0] volt;
    logic       over_warn;
    logic       fast_trip;
    logic       slow_trip;
    logic       oc_limit;
  } hsc_meas_s;
endpackage

// *** logic/hsc_channel_control.sv ***
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Operation
// RULE1: channel on needs enable_b and arm high
// RULE2: enable strap high sets both enable_b
// RULE3: later strap drop never clears enable_b
// RULE4: host may rewrite each enable_b bit
// RULE5: arm status bit follows arm comparator
// RULE6: grouping strap sampled once, then ignored
// RULE7: fault action strap: power-good only, or shutdown
// RULE8: alert low on limit or overcurrent after good
// RULE9: power-good only within undervoltage/overvoltage limits
// RULE10: polarity strap sets power-good active level
// RULE11: fault output low on breaker shutdown
// RULE12: fast or slow trip is breaker shutdown
// RULE13: retry strap latched once, autoretry or latch-off
// RULE14: autoretry clears fault, restarts after 200ms
// RULE15: latch-off holds until arm/enable toggle or power
// RULE16: settings loaded before any channel enabled
// RULE17: retry delay counter, cleared when disabled
// RULE18: straps sampled once at init end
//
// reset and init
// - external reset is asynchronous, active low
// - release passes two flops before use
// - internal reset reaches every register below
// - init phase counts a fixed number of edges
// - straps are captured on the last init edge
// - enable_b is seeded on that same edge
// - no channel can switch on during init
// - captured straps hold until the next reset
// - strap pins are not watched after init
//
// register bus
// - classic single-cycle slave
// - a request is taken while ack is low
// - ack follows one edge after it is taken
// - ack stands for exactly one cycle
// - read data stands only beside ack
// - writes need byte lane zero
// - limit writes also need byte lane one
// - unmapped reads give zero, writes vanish
// - ctrl writes in init are ignored
// - the strap seed would overwrite enable_b anyway
//
// channel enable
// - both enable bits and arm must be high
// - arm takes one flop before use
// - the init phase gates every channel
// - a tripped channel stays off
// - channel_on is one edge behind its terms
//
// power-good
// - needs the channel on and volt in range
// - both limit compares are strict
// - any trip drops power-good at once
// - this holds in both fault actions
// - output level follows the captured strap
// - losing power-good raises a sticky event
//
// breaker faults
// - fast or slow trip counts as breaker event
// - grouped mode trips both channels together
// - fault_n drops on the shutdown edge
// - only the shutdown action sets fault_n low
// - power-good-only action leaves fault_n high
//
// autoretry
// - fault_n is released the cycle after shutdown
// - a counter then runs on every edge
// - the channel restarts when it expires
// - the counter clears while disabled
// - a trip still present trips again at once
//
// latch-off
// - the channel stays off after shutdown
// - a rising edge of the combined enable clears it
// - arm, enable_a or enable_b toggle all count
// - a reset also clears it
//
// alert
// - quiet until a power-good has been seen
// - over_warn or oc_limit pull it low
// - warn enable masks those per channel
// - an on channel out of range pulls it low
// - it is registered, so it lags one edge
//
// interrupts
// - sticky status bits, write one to clear
// - a new event in the clear cycle wins
// - mask register has the same layout
// - irq_out is high while an unmasked bit is set
//
// limits of this block
// - measurement words arrive already sampled
// - comparator hysteresis lives outside
// - retry count is in clock cycles, not time
// - changing the clock needs a new count
// - channel count above two needs a wider irq map
//
// hazards kept in mind
// - selection logic is continuous wires, except the always_comb read mux
// - no function reads module state implicitly
// - set beats clear on every sticky flag
// - every output comes straight from a flop
// - the reset copy is only read after two flops
// - straps are never read outside init
//
module hsc_channel_control
  import hsc_pkg::*;
#(
  parameter int RETRY_COUNT = RETRY_CYCLES,
  parameter int NCH         = 2
) (
  input  wire logic            sys_clk_in,
  input  wire logic            rst_n_in,
  input  wire logic [31:0]     wb_adr_in,
  input  wire logic [31:0]     wb_dat_in,
  input  wire logic [3:0]      wb_sel_in,
  input  wire logic            wb_we_in,
  input  wire logic            wb_cyc_in,
  input  wire logic            wb_stb_in,
  output logic      [31:0]     wb_dat_out,
  output logic                 wb_ack_out,
  input  wire logic [NCH-1:0]  arm_cmp_in,
  input  wire hsc_straps_s     straps_in,
  input  wire logic            hw_enable_strap_in,
  input  wire hsc_meas_s [NCH-1:0] meas_in,
  output logic      [NCH-1:0]  channel_on_out,
  output logic      [NCH-1:0]  power_good_out,
  output logic      [NCH-1:0]  fault_n_out,
  output logic                 alert_n_out,
  output logic                 irq_out
);
  localparam int CW = $clog2(RETRY_COUNT + 1);
  localparam int IW = $clog2(INIT_CYCLES + 1);

  // reset release through two flops
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // power-up init phase, straps captured once at its end
  hsc_phase_e  phase;
  logic [IW-1:0] init_cnt;
  hsc_straps_s straps;
  logic        strap_en_b;
  wire         init_done = (init_cnt == IW'(INIT_CYCLES - 1));
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      phase      <= HSC_INIT;
      init_cnt   <= '0;
      straps     <= '0;
      strap_en_b <= 1'b0;
    end else begin
      case (phase)
        HSC_INIT: begin
          init_cnt <= init_cnt + IW'(1);
          if (init_done) begin
            straps     <= straps_in;            // RULE6 RULE13 RULE18
            strap_en_b <= hw_enable_strap_in;   // RULE2
            phase      <= HSC_RUN;
          end
        end
        default: phase <= HSC_RUN;              // RULE3 RULE18
      endcase
    end
  end
  wire running = (phase == HSC_RUN);

  // bus decode
  wire        req     = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire        wr      = req && wb_we_in && wb_sel_in[0];
  wire        wr_hi   = req && wb_we_in && wb_sel_in[1];
  wire [7:0]  adr     = wb_adr_in[7:0];
  wire        sel_ctrl = (adr == OFF_CTRL);
  wire        sel_irq  = (adr == OFF_IRQ);
  wire        sel_mask = (adr == OFF_MASK);
  wire        sel_warn = (adr == OFF_WARN);
  wire [9:0]  wdat10   = wb_dat_in[9:0];

  logic [1:0] en_a;
  logic [1:0] en_b;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [9:0] lim_uv [NCH];
  logic [9:0] lim_ov [NCH];
  logic [NCH-1:0] warn_en;
  logic [NCH-1:0] armed;
  logic [NCH-1:0] cb_evt;
  logic [NCH-1:0] pg_lost;
  logic [NCH-1:0] good_raw;
  logic       seen_good;

  // control regs; enable_b seeded from strap once init ends
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      en_a     <= EN_A_RESET;
      en_b     <= 2'h0;
      irq_mask <= 4'h0;
      warn_en  <= '1;
    end else begin
      if (phase == HSC_INIT && init_done) begin
        en_b <= {2{hw_enable_strap_in}};                           // RULE2 RULE16
      end else if (wr && sel_ctrl && running) begin
        en_a <= wb_dat_in[CTRL_EN_A_LSB +: 2];
        en_b <= wb_dat_in[CTRL_EN_B_LSB +: 2];                     // RULE4
      end
      if (wr && sel_mask) irq_mask <= wb_dat_in[3:0];
      if (wr && sel_warn) warn_en <= wb_dat_in[NCH-1:0];
    end
  end

  // sticky events: set wins over write-one-to-clear
  wire [3:0] irq_set = {pg_lost[1], pg_lost[0], cb_evt[1], cb_evt[0]};
  wire [3:0] irq_clr = (wr && sel_irq) ? wb_dat_in[3:0] : 4'h0;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) irq_stat <= 4'h0;
    else irq_stat <= (irq_stat & ~irq_clr) | irq_set;
  end

  // per-channel limits, fault state and retry timer
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      wire [9:0] v       = meas_in[g].volt;
      wire       in_lim  = (v > lim_uv[g]) && (v < lim_ov[g]);       // RULE9
      wire       trip    = meas_in[g].fast_trip || meas_in[g].slow_trip; // RULE12
      // grouped mode: both channels trip together
      wire       trip_any = straps.group_both ?
                           (meas_in[0].fast_trip || meas_in[0].slow_trip ||
                            meas_in[NCH-1].fast_trip || meas_in[NCH-1].slow_trip) : trip;
      wire       want    = en_a[g] && en_b[g] && armed[g] && running;  // RULE1 RULE16
      logic      want_q;
      logic      tripped;
      logic [CW-1:0] rcnt;
      wire       act_on  = want && !tripped;
      wire       rearm   = want && !want_q;                            // RULE15
      wire       retry_done = (rcnt == CW'(RETRY_COUNT - 1));
      // shutdown only when strap says so, else power-good only
      wire       shut    = trip_any && act_on && straps.shutdown_on_fault; // RULE7
      // any trip drops power-good in both fault actions
      assign good_raw[g] = act_on && in_lim && !trip_any;              // RULE7 RULE9
      assign cb_evt[g]   = shut;
      assign pg_lost[g]  = power_good_out[g] != (good_raw[g] ~^ straps.good_active_high) &&
                           (power_good_out[g] == straps.good_active_high);
      always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          lim_uv[g] <= UV_RESET;
          lim_ov[g] <= OV_RESET;
        end else begin
          if (wr && wr_hi && adr == OFF_LIMUV0 + 8'(8 * g)) lim_uv[g] <= wdat10;
          if (wr && wr_hi && adr == OFF_LIMOV0 + 8'(8 * g)) lim_ov[g] <= wdat10;
        end
      end
      always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          armed[g]          <= 1'b0;
          want_q            <= 1'b0;
          tripped           <= 1'b0;
          rcnt              <= '0;
          channel_on_out[g] <= 1'b0;
          fault_n_out[g]    <= 1'b1;
          power_good_out[g] <= 1'b0;
        end else begin
          armed[g] <= arm_cmp_in[g];                                   // RULE5
          want_q   <= want;
          if (shut) begin
            tripped        <= 1'b1;
            fault_n_out[g] <= 1'b0;                                    // RULE11
            rcnt           <= '0;
          end else if (!want) begin
            rcnt <= '0;                                                // RULE17
          end else if (tripped && rearm) begin
            tripped        <= 1'b0;                                    // RULE15
            fault_n_out[g] <= 1'b1;
          end else if (tripped && straps.autoretry) begin
            fault_n_out[g] <= 1'b1;                                    // RULE14
            rcnt           <= rcnt + CW'(1);                           // RULE17
            if (retry_done) tripped <= 1'b0;                           // RULE14
          end
          channel_on_out[g] <= act_on && !shut;                        // RULE1
          power_good_out[g] <= good_raw[g] ~^ straps.good_active_high; // RULE10
        end
      end
    end
  endgenerate

  // alert only armed after a power-good has been seen
  wire limit_bad0 = warn_en[0] && (meas_in[0].over_warn || meas_in[0].oc_limit);
  wire limit_bad1 = warn_en[NCH-1] && (meas_in[NCH-1].over_warn || meas_in[NCH-1].oc_limit);
  // plain wire so every term is in the sensitivity
  wire any_off    = |(channel_on_out & ~good_raw);
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      seen_good   <= 1'b0;
      alert_n_out <= 1'b1;
      irq_out     <= 1'b0;
    end else begin
      if (|good_raw) seen_good <= 1'b1;
      alert_n_out <= !(seen_good && (limit_bad0 || limit_bad1 || any_off)); // RULE8
      irq_out     <= |(irq_stat & irq_mask);
    end
  end

  // read mux, one-cycle ack
  wire [31:0] rd_ctrl   = {28'h0, en_b, en_a};
  wire [31:0] rd_status = {22'h0, straps, strap_en_b, running, armed, ~fault_n_out};
  logic [31:0] rd_mux;
  // address decode, unmapped reads give zero
  always_comb begin
    rd_mux = 32'h0;
    if (adr == OFF_CTRL) begin
      rd_mux = rd_ctrl;
    end else if (adr == OFF_STATUS) begin
      rd_mux = rd_status;
    end else if (adr == OFF_IRQ) begin
      rd_mux = {28'h0, irq_stat};
    end else if (adr == OFF_MASK) begin
      rd_mux = {28'h0, irq_mask};
    end else if (adr == OFF_LIMUV0) begin
      rd_mux = {22'h0, lim_uv[0]};
    end else if (adr == OFF_LIMOV0) begin
      rd_mux = {22'h0, lim_ov[0]};
    end else if (adr == OFF_LIMUV1) begin
      rd_mux = {22'h0, lim_uv[NCH-1]};
    end else if (adr == OFF_LIMOV1) begin
      rd_mux = {22'h0, lim_ov[NCH-1]};
    end else if (adr == OFF_WARN) begin
      rd_mux = {{(32-NCH){1'b0}}, warn_en};
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= req;
      wb_dat_out <= req ? rd_mux : 32'h0;
    end
  end
endmodule

// *** tb/hsc_channel_control_props.sv ***
`timescale 1ns/1ps
module hsc_channel_control_props
  import hsc_pkg::*;
#(
  parameter int RETRY_COUNT = RETRY_CYCLES,
  parameter int NCH         = 2
) (
  input wire logic               sys_clk_in,
  input wire logic               rst_n_in,
  input wire logic [31:0]        wb_adr_in,
  input wire logic [31:0]        wb_dat_in,
  input wire logic [3:0]         wb_sel_in,
  input wire logic               wb_we_in,
  input wire logic               wb_cyc_in,
  input wire logic               wb_stb_in,
  input wire logic [31:0]        wb_dat_out,
  input wire logic               wb_ack_out,
  input wire logic [NCH-1:0]     arm_cmp_in,
  input wire hsc_straps_s        straps_in,
  input wire logic               hw_enable_strap_in,
  input wire hsc_meas_s [NCH-1:0] meas_in,
  input wire logic [NCH-1:0]     channel_on_out,
  input wire logic [NCH-1:0]     power_good_out,
  input wire logic [NCH-1:0]     fault_n_out,
  input wire logic               alert_n_out,
  input wire logic               irq_out
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // bus handshake: one-cycle answer, one-cycle ack, only on request
  a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held too long");
  a_ack_answers: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("no ack");
  a_ack_has_cause: assert property (wb_ack_out |-> $past(wb_stb_in)) else $error("ack without request");
  a_unmapped_zero: assert property (wb_stb_in && !wb_we_in && wb_adr_in == 32'h40 && !wb_ack_out
    |=> wb_dat_out == 32'h0) else $error("unmapped read not zero");
  // arm passes one sync flop before the registered enable
  a_on_needs_arm: assert property ((channel_on_out & ~$past(arm_cmp_in, 2)) == '0) else $error("on unarmed");
  a_fault_means_off: assert property ((channel_on_out & ~fault_n_out) == '0) else $error("on while tripped");
  a_retry_wait: assert property ($fell(fault_n_out[0]) |-> !channel_on_out[0] [*8]) else $error("restart early");
  a_init_quiet: assert property ($rose(rst_n_in) |-> (channel_on_out == '0) [*8]) else $error("on in init");
  c_trip: cover property ($fell(fault_n_out[0]));
  c_irq: cover property ($rose(irq_out));
  c_alert: cover property ($fell(alert_n_out));
endmodule
bind hsc_channel_control hsc_channel_control_props #(.RETRY_COUNT(RETRY_COUNT), .NCH(NCH)) u_props (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
  .wb_sel_in(wb_sel_in), .wb_we_in(wb_we_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .arm_cmp_in(arm_cmp_in), .straps_in(straps_in),
  .hw_enable_strap_in(hw_enable_strap_in), .meas_in(meas_in), .channel_on_out(channel_on_out),
  .power_good_out(power_good_out), .fault_n_out(fault_n_out), .alert_n_out(alert_n_out), .irq_out(irq_out));

// *** tb/hsc_host_model.sv ***
`timescale 1ns/1ps
module hsc_host_model (
  input  wire logic       good_high_in,
  input  wire logic [1:0] power_good_in,
  output logic      [1:0] good_out
);
  // host reads the pins at the level the polarity strap chose
  assign good_out = good_high_in ? power_good_in : ~power_good_in;
endmodule

// *** tb/hsc_channel_control_tb_top.sv ***
`timescale 1ns/1ps
module hsc_channel_control_tb_top;
  import hsc_pkg::*;
  localparam hsc_meas_s OK = '{volt:10'h200, default:'0};
  logic [31:0]     adr, wdat, rdat, q;
  logic            clk, rst_n, we, cyc, stb, ack, hw_enable_strap, alert_n, irq;
  logic [3:0]      sel;
  logic [1:0]      arm, on, pg, flt_n, good;
  logic [7:0]      obs;
  hsc_straps_s     straps;
  hsc_meas_s [1:0] meas;
  int              error_cnt, cmp_count;
  assign obs = {irq, alert_n, flt_n, pg, on};
  always #2.5 clk = ~clk;
  // short retry count keeps the run brief
  hsc_channel_control #(.RETRY_COUNT(20)) DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .wb_adr_in(adr),
    .wb_dat_in(wdat), .wb_sel_in(sel), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_dat_out(rdat),
    .wb_ack_out(ack), .arm_cmp_in(arm), .straps_in(straps), .hw_enable_strap_in(hw_enable_strap), .meas_in(meas),
    .channel_on_out(on), .power_good_out(pg), .fault_n_out(flt_n), .alert_n_out(alert_n), .irq_out(irq));
  // only the active-low run asks the host for its view
  hsc_host_model u_host (.good_high_in(1'b0), .power_good_in(pg), .good_out(good));
  task automatic summarize();
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // request stands until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, 24'h0, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 40) chk("ack", 32'h0, 32'h1);
    if (n >= 40) summarize();
  endtask
  // bounded wait for masked outputs, then compare
  task automatic wt(input string nm, input logic [7:0] m, input logic [7:0] v);
    int i;
    for (i = 0; i < 60 && (obs & m) !== v; i++) @(posedge clk);
    chk(nm, {24'h0, obs & m}, {24'h0, v});
  endtask
  task automatic boot(input hsc_straps_s s, input logic h);
    {rst_n, arm, hw_enable_strap, straps} <= {3'b000, h, s};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (25) @(posedge clk);
  endtask
  // main sequence: autoretry run, then latch-off grouped active-low run
  initial begin
    {clk, sel, meas, error_cnt, cmp_count} = {1'b0, 4'hF, OK, OK, 64'h0};
    {cyc, stb, we, adr, wdat} = '0;
    boot(4'b0111, 1'b1);
    {hw_enable_strap, straps} <= 5'h00;
    wb(OFF_CTRL, 1'b0, 32'h0);
    chk("ctrl", q, 32'hF);
    arm <= 2'b11;
    wt("on", 8'h3F, 8'h3F);
    wb(OFF_STATUS, 1'b0, 32'h0);
    chk("status", q & 32'h3EC, 32'h1EC);
    wb(8'h40, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(OFF_CTRL, 1'b1, 32'h7);
    wt("en_b", 8'h0F, 8'h05);
    wb(OFF_CTRL, 1'b1, 32'hF);
    wb(OFF_MASK, 1'b1, 32'h0);
    meas[0] <= '{volt:10'h200, fast_trip:1'b1, default:'0};
    wt("trip", 8'h1F, 8'h0A);
    meas[0] <= OK;
    wt("retry", 8'h9F, 8'h1F);
    wb(OFF_IRQ, 1'b0, 32'h0);
    chk("irq", q & 32'h1, 32'h1);
    wb(OFF_MASK, 1'b1, 32'hF);
    wt("unmasked", 8'h80, 8'h80);
    wb(OFF_IRQ, 1'b1, 32'hF);
    wb(OFF_IRQ, 1'b0, 32'h0);
    chk("w1c", q & 32'hF, 32'h0);
    meas[1] <= '{volt:10'h200, over_warn:1'b1, default:'0};
    wt("alert", 8'h40, 8'h00);
    meas[1] <= '{volt:10'h3F0, default:'0};
    wt("limit", 8'h08, 8'h00);
    meas[1] <= OK;
    boot(4'b1100, 1'b0);
    wb(OFF_CTRL, 1'b0, 32'h0);
    chk("ctrl0", q, 32'h3);
    arm <= 2'b11;
    wb(OFF_CTRL, 1'b1, 32'hF);
    wt("low pg", 8'h0F, 8'h03);
    chk("host", {30'h0, good}, 32'h3);
    meas[0] <= '{volt:10'h200, slow_trip:1'b1, default:'0};
    wt("group", 8'h13, 8'h00);
    meas[0] <= OK;
    repeat (80) @(posedge clk);
    wt("latched", 8'h13, 8'h00);
    arm <= 2'b00;
    repeat (4) @(posedge clk);
    arm <= 2'b11;
    wt("rearm", 8'h13, 8'h13);
    summarize();
  end
endmodule
